//--- rlsr_pkg.sv
// Purpose: Shared constants and types for the reference level refresh controller.
// Assumes: 20 MHz system clock; classic Wishbone register access.
// Notes: All counts derive from the figures below.
package rlsr_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // Serial word layout, most significant bit shifted first
  localparam int WORD_BITS = 16;
  localparam int TEST_BIT_POS = 15;
  localparam int SOURCE_BIT_POS = 14;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 10;
  localparam int LEVEL_MSB = 9;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_BITS = 10;
  localparam int ADDR_BITS = 4;
  localparam int NUM_CHANNELS = 10;

  // Level code scale: full scale is the code span
  localparam int LEVEL_SPAN = 1024;
  localparam logic [9:0] LEVEL_MAX_CODE = 10'h3FF;
  localparam logic [9:0] LEVEL_HALF_CODE = 10'h200;

  // Internal refresh oscillator
  localparam int OSC_FREQ_HZ = 21_000;
  localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_FREQ_HZ);

  // Serial clock least period, rounded up to whole system cycles
  localparam int SCLK_MIN_PERIOD_NS = 200;
  localparam int SCLK_MIN_CYCLES = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Code to output latency window, in microseconds and refresh periods
  localparam int LATENCY_BEST_US = 48;
  localparam int LATENCY_WORST_US = 480;
  localparam int LATENCY_WORST_REFRESHES = NUM_CHANNELS;

  // Register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_STEP = 8'h04;
  localparam logic [7:0] REG_VIEW_SEL = 8'h08;
  localparam logic [7:0] REG_LEVEL_VIEW = 8'h0C;

  // Status and level view field positions
  localparam int ST_EXT_MODE = 0;
  localparam int ST_PIN_DRIVE = 1;
  localparam int ST_SWITCH = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_CHAN_LSB = 4;
  localparam int VIEW_APPLIED_LSB = 16;

  // Step limit per refresh, in code units; reset value
  localparam logic [9:0] STEP_RESET = 10'h080;
  localparam logic [3:0] VIEW_SEL_RESET = 4'h0;

  typedef struct packed {
    logic reservedTestBit;
    logic refreshSourceBit;
    logic [3:0] channelAddr;
    logic [9:0] levelCode;
  } rlsr_word_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_HOLD = 2'b11
  } rlsr_phase_type;

endpackage

//--- rlsr_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs are slow levels relative to clk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module rlsr_sync #(
  parameter int WIDTH = 4,
  // Each bit starts at its pin's idle level, so leaving reset makes no false edge
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output var logic [WIDTH-1:0] syncOut
);
  import rlsr_pkg::*;

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_reg <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

//--- rlsr_osc.sv
// Purpose: Internal refresh oscillator, divided down from the system clock.
// Assumes: HALF_CYCLES of at least one.
// Notes: Starts low after reset.
`timescale 1ns/1ns
`default_nettype none
module rlsr_osc #(
  parameter int HALF_CYCLES = rlsr_pkg::OSC_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  output var logic oscOut
);
  import rlsr_pkg::*;

  localparam logic [15:0] LAST = 16'(HALF_CYCLES - 1);
  logic [15:0] count_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= '0;
      oscOut <= 1'b0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
      oscOut <= ~oscOut;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- rlsr_reference_level_ctrl.sv
// Purpose: Serial word capture, refresh clock selection and channel refresh rotation.
// Assumes: Serial pins and refresh pin are asynchronous and sampled by clk.
// Notes: Analog stage takes levelOut codes and sampleSwitchClosed per channel.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Level field is 10-bit unsigned binary
// - 4-bit binary address picks the channel
// - Output equals low plus code/1024 of span
// - Source bit one external, zero internal
// - Internal oscillator mode after power-up
// - Refresh pin undriven at power-up
// - About 21kHz internal clock driven on pin
// - External mode takes refresh clock from pin
// - Refresh starts on refresh clock falling edge
// - Switches open on rising edge, hold
// - Channels refreshed in continuous rotation
// - Latency about 48us best, 480us worst
// - Large changes move in bounded steps
// - Shift 16 bits MSB first while framed
// - Load on frame end; ignore clock otherwise
// - Chain out after 16th falling edge
// - Each channel refreshed every ten cycles
module rlsr_reference_level_ctrl #(
  parameter int NUM_CHAN = rlsr_pkg::NUM_CHANNELS,
  parameter int OSC_HALF = rlsr_pkg::OSC_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic serial_in,
  input wire logic frame_select_n,
  output var logic serial_chain_out,
  input wire logic refresh_clock_pin_in,
  output logic refresh_clock_pin_out,
  output logic refresh_clock_pin_oe,
  output logic [NUM_CHAN*rlsr_pkg::LEVEL_BITS-1:0] levelOut,
  output var logic sampleSwitchClosed,
  output var logic [rlsr_pkg::ADDR_BITS-1:0] refreshChannel,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output var logic [31:0] wb_dat_o,
  output var logic wb_ack_o
);
  import rlsr_pkg::*;

  localparam logic [ADDR_BITS-1:0] LAST_CHAN = ADDR_BITS'(NUM_CHAN - 1);
  localparam logic [4:0] FULL_COUNT = 5'(WORD_BITS);

  // Synchronised pins
  logic [3:0] pinSync;
  logic sclkS, sdiS, frameNS, refPinS;
  // Frame select resets high, its idle level, so no frame seems to open after reset
  rlsr_sync #(.WIDTH(4), .RESET_VAL(4'h2)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({serialClk, serial_in, frame_select_n, refresh_clock_pin_in}),
    .syncOut(pinSync)
  );
  assign {sclkS, sdiS, frameNS, refPinS} = pinSync;

  logic oscClk;
  rlsr_osc #(.HALF_CYCLES(OSC_HALF)) u_osc (
    .clk(clk),
    .sys_rst(sys_rst),
    .oscOut(oscClk)
  );

  // Edge detection on synchronised copies
  logic sclkPrev_reg, framePrev_reg, refPrev_reg;
  logic refClkSel;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclkPrev_reg <= 1'b0;
      framePrev_reg <= 1'b1;
      refPrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkS;
      framePrev_reg <= frameNS;
      refPrev_reg <= refClkSel;
    end
  end

  logic sclkRise, sclkFall, frameStart, frameEnd;
  assign sclkRise = sclkS & ~sclkPrev_reg & ~frameNS;
  assign sclkFall = ~sclkS & sclkPrev_reg & ~frameNS;
  assign frameStart = ~frameNS & framePrev_reg;
  assign frameEnd = frameNS & ~framePrev_reg;

  // Serial shift register
  logic [WORD_BITS-1:0] shift_reg;
  logic [4:0] bitCount_reg;
  rlsr_word_type word;
  logic loadWord;
  assign word = rlsr_word_type'(shift_reg);
  // Short frames are dropped; longer ones keep the last sixteen bits for daisy chains
  assign loadWord = frameEnd && (bitCount_reg == FULL_COUNT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else if (sclkRise) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], sdiS};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitCount_reg <= '0;
    end else if (frameStart) begin
      bitCount_reg <= '0;
    end else if (sclkRise && bitCount_reg != FULL_COUNT) begin
      bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_chain_out <= 1'b0;
    end else if (sclkFall) begin
      serial_chain_out <= shift_reg[WORD_BITS-1];
    end
  end

  // Refresh source mode and pin drive
  logic extMode_reg, pinDrive_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extMode_reg <= 1'b0;
      pinDrive_reg <= 1'b0;
    end else if (loadWord) begin
      extMode_reg <= word.refreshSourceBit;
      pinDrive_reg <= ~word.refreshSourceBit;
    end
  end

  assign refresh_clock_pin_oe = pinDrive_reg;
  assign refresh_clock_pin_out = oscClk;
  // Switching source may give one spurious edge; it only advances the rotation by one
  assign refClkSel = extMode_reg ? refPinS : oscClk;

  logic refFall, refRise;
  assign refFall = ~refClkSel & refPrev_reg;
  assign refRise = refClkSel & ~refPrev_reg;

  // Refresh rotation and sample switch phase
  rlsr_phase_type phase_reg;
  logic [ADDR_BITS-1:0] nextChan;
  assign nextChan = (refreshChannel == LAST_CHAN) ? '0 : refreshChannel + 4'h1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refreshChannel <= LAST_CHAN;
    end else if (refFall) begin
      refreshChannel <= nextChan;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= PH_IDLE;
    end else begin
      case (phase_reg)
        PH_IDLE: if (refFall) phase_reg <= PH_SAMPLE;
        PH_SAMPLE: if (refRise) phase_reg <= PH_HOLD;
        PH_HOLD: if (refFall) phase_reg <= PH_SAMPLE;
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampleSwitchClosed <= 1'b0;
    end else if (refFall) begin
      sampleSwitchClosed <= 1'b1;
    end else if (refRise) begin
      sampleSwitchClosed <= 1'b0;
    end
  end

  // Step limit per refresh, written by software
  logic [LEVEL_BITS-1:0] stepLimit_reg;
  logic [ADDR_BITS-1:0] viewSel_reg;

  // Per-channel stored and applied codes
  logic [LEVEL_BITS-1:0] storedCode_reg [NUM_CHAN];
  logic [LEVEL_BITS-1:0] appliedLevel_reg [NUM_CHAN];

  function automatic logic [LEVEL_BITS-1:0] stepToward(
    input logic [LEVEL_BITS-1:0] cur,
    input logic [LEVEL_BITS-1:0] target,
    input logic [LEVEL_BITS-1:0] lim
  );
    logic [LEVEL_BITS-1:0] diff;
    diff = (target > cur) ? target - cur : cur - target;
    if (diff <= lim) begin
      stepToward = target;
    end else if (target > cur) begin
      stepToward = cur + lim;
    end else begin
      stepToward = cur - lim;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : gen_chan
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          storedCode_reg[g] <= '0;
        end else if (loadWord && word.channelAddr == ADDR_BITS'(g)) begin
          storedCode_reg[g] <= word.levelCode;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          appliedLevel_reg[g] <= '0;
        end else if (refFall && nextChan == ADDR_BITS'(g)) begin
          appliedLevel_reg[g] <= stepToward(appliedLevel_reg[g], storedCode_reg[g],
                                            stepLimit_reg);
        end
      end

      // Analog stage forms low + code/1024 * (high - low) from this code
      assign levelOut[g*LEVEL_BITS +: LEVEL_BITS] = appliedLevel_reg[g];
    end
  endgenerate

  // Wishbone slave: one wait state, ack for one cycle
  logic wbReq;
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stepLimit_reg <= STEP_RESET;
      viewSel_reg <= VIEW_SEL_RESET;
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i == REG_STEP) begin
        if (wb_sel_i[0]) stepLimit_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) stepLimit_reg[9:8] <= wb_dat_i[9:8];
      end
      if (wb_adr_i == REG_VIEW_SEL && wb_sel_i[0]) begin
        viewSel_reg <= wb_dat_i[3:0];
      end
    end
  end

  logic [LEVEL_BITS-1:0] viewStored, viewApplied;
  always_comb begin
    viewStored = '0;
    viewApplied = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (viewSel_reg == ADDR_BITS'(i)) begin
        viewStored = storedCode_reg[i];
        viewApplied = appliedLevel_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_dat_o <= '0;
    end else if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: begin
          wb_dat_o <= '0;
          wb_dat_o[ST_EXT_MODE] <= extMode_reg;
          wb_dat_o[ST_PIN_DRIVE] <= pinDrive_reg;
          wb_dat_o[ST_SWITCH] <= sampleSwitchClosed;
          wb_dat_o[ST_FRAME] <= ~frameNS;
          wb_dat_o[ST_CHAN_LSB +: ADDR_BITS] <= refreshChannel;
        end
        REG_STEP: wb_dat_o <= {22'h000000, stepLimit_reg};
        REG_VIEW_SEL: wb_dat_o <= {28'h0000000, viewSel_reg};
        REG_LEVEL_VIEW: wb_dat_o <= {6'h00, viewApplied, 6'h00, viewStored};
        default: wb_dat_o <= '0;
      endcase
    end else begin
      wb_dat_o <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_shift_in_order: assert property (sclkRise |=> shift_reg[0] == $past(sdiS)
    && shift_reg[WORD_BITS-1:1] == $past(shift_reg[WORD_BITS-2:0]))
    else $error("serial bit not shifted in order");
  a_idle_no_shift: assert property (frameNS && $past(frameNS) |=> $stable(shift_reg))
    else $error("shift register moved outside a frame");
  a_chain_out_bit: assert property (sclkFall |=> serial_chain_out == $past(shift_reg[15]))
    else $error("chain output does not follow top shift bit");
  a_mode_from_word: assert property (loadWord |=> extMode_reg == $past(word.refreshSourceBit)
    && refresh_clock_pin_oe == !extMode_reg)
    else $error("refresh source not taken from loaded word");
  a_pin_hiz_power: assert property ($past(sys_rst) || (!$past(refresh_clock_pin_oe)
    && !$past(loadWord)) |-> !refresh_clock_pin_oe)
    else $error("refresh pin driven without an internal mode word");
  a_stored_code: assert property (loadWord && word.channelAddr == 4'h3 && NUM_CHAN > 3
    |=> storedCode_reg[3] == $past(word.levelCode))
    else $error("addressed channel did not store code");
  a_rotate_next: assert property (refFall |=> refreshChannel == $past(nextChan)
    && refreshChannel <= LAST_CHAN)
    else $error("refresh rotation out of order");
  a_switch_opens: assert property (refRise && !refFall |=> !sampleSwitchClosed
    ##1 (!sampleSwitchClosed || $past(refFall)))
    else $error("sample switch not opened on rising edge");
  a_switch_closes: assert property (refFall |=> sampleSwitchClosed
    && phase_reg == PH_SAMPLE)
    else $error("refresh not started on falling edge");
  a_step_bounded: assert property (refFall && nextChan == 4'h0 |=>
    ((appliedLevel_reg[0] >= $past(appliedLevel_reg[0])) ?
      appliedLevel_reg[0] - $past(appliedLevel_reg[0]) :
      $past(appliedLevel_reg[0]) - appliedLevel_reg[0]) <= $past(stepLimit_reg))
    else $error("applied level stepped beyond limit");
  a_wb_ack_once: assert property (wbReq |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");

  c_word_loaded: cover property (loadWord && !word.refreshSourceBit);
  c_ext_mode: cover property (loadWord && word.refreshSourceBit);
  c_full_rotation: cover property (refFall && nextChan == LAST_CHAN);
  c_wb_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == REG_LEVEL_VIEW);
endmodule
`default_nettype wire

//--- rlsr_host_model.sv
// Purpose: Host controller model driving the three-wire serial port.
// Assumes: Called from a process on clk; halfCyc of at least 4.
// Notes: Serial clock stands still low outside frames, except in stray().
`timescale 1ns/1ns
`default_nettype none
module rlsr_host_model (
  input wire logic clk,
  input wire logic serial_chain_out,
  output var logic serialClk,
  output var logic serial_in,
  output var logic frame_select_n
);
  initial begin
    serialClk = 1'b0;
    serial_in = 1'b0;
    frame_select_n = 1'b1;
  end

  // Sends the low nBits of w, top bit first; echo holds what the chain showed
  // before each of the last 16 rises
  task automatic send(input logic [31:0] w, input int nBits, input int halfCyc,
      output logic [15:0] echo);
    echo = 16'h0000;
    @(posedge clk);
    frame_select_n <= 1'b0;
    for (int i = nBits - 1; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (halfCyc) @(posedge clk);
      if (i < 16) echo = {echo[14:0], serial_chain_out};
      serialClk <= 1'b1;
      repeat (halfCyc) @(posedge clk);
      serialClk <= 1'b0;
    end
    repeat (halfCyc) @(posedge clk);
    frame_select_n <= 1'b1;
    // Released data line must not look like a held bit
    serial_in <= ~serial_in;
  endtask

  // Clock pulses with the frame closed, which the device must ignore
  task automatic stray(input int n, input int halfCyc);
    repeat (n) begin
      repeat (halfCyc) @(posedge clk);
      serialClk <= 1'b1;
      serial_in <= ~serial_in;
      repeat (halfCyc) @(posedge clk);
      serialClk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- reference_level_serial_refresh_ctrl_tb.sv
// Purpose: Self-checking bench for the reference level refresh controller.
// Assumes: Oscillator half period shortened to 100 system cycles.
// Notes: Writes start just after the target channel's refresh so the model stays exact.
`timescale 1ns/1ns
`default_nettype none
module reference_level_serial_refresh_ctrl_tb;
  import rlsr_pkg::*;
  localparam int HALF = 100;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sClk, sIn, frameN, chainOut, pinOut, pinOe, sw, ack;
  logic extClk = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, extMode = 1'b0, prevSw = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] rch;
  logic [31:0] datW = 32'h0, datR;
  logic [NUM_CHANNELS*LEVEL_BITS-1:0] lvl;
  logic [9:0] tgt [NUM_CHANNELS];
  logic [9:0] app [NUM_CHANNELS];
  logic [9:0] stepVal = STEP_RESET;
  logic [31:0] expQ [$];
  logic [31:0] mskQ [$];
  logic [15:0] echo;
  logic [15:0] wordA;
  logic [9:0] code;
  int failures = 0, checks_done = 0, cycles = 0, lastChan = 9, skipPin = 0;
  // Pin has no pull: undriven, it carries the free-running outside clock
  wire logic pinWire = pinOe ? pinOut : extClk;

  always #25 clk = ~clk;
  always begin
    repeat (HALF) @(posedge clk);
    extClk <= ~extClk;
  end

  rlsr_host_model rlsr_host_model_inst (.clk(clk), .serial_chain_out(chainOut),
    .serialClk(sClk), .serial_in(sIn), .frame_select_n(frameN));
  rlsr_reference_level_ctrl #(.NUM_CHAN(NUM_CHANNELS), .OSC_HALF(HALF))
    rlsr_reference_level_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .serialClk(sClk),
    .serial_in(sIn), .frame_select_n(frameN), .serial_chain_out(chainOut),
    .refresh_clock_pin_in(pinWire), .refresh_clock_pin_out(pinOut),
    .refresh_clock_pin_oe(pinOe), .levelOut(lvl), .sampleSwitchClosed(sw),
    .refreshChannel(rch), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack));

  task automatic cmp_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_bus(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Read data is taken at the rising edge at which ack is seen high
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) begin
      cmp_bus("readData", expQ[0] & mskQ[0], datR & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end

  // Refresh events are compared here as they appear
  always @(negedge clk) begin
    logic [9:0] c;
    logic [9:0] d;
    if (sys_rst) begin
      lastChan = 9;
    end else if (sw === 1'b1 && !prevSw) begin
      lastChan = (lastChan + 1) % NUM_CHANNELS;
      c = app[lastChan];
      d = tgt[lastChan];
      if (d > c) app[lastChan] = (d - c > stepVal) ? c + stepVal : d;
      else app[lastChan] = (c - d > stepVal) ? c - stepVal : d;
      cmp_bus("refreshChannel", 32'(lastChan), {28'h0, rch});
      cmp_bus("levelOut", {22'h0, app[lastChan]}, {22'h0, lvl[lastChan*10+:10]});
      if (skipPin > 0) skipPin--;
      else if (pinOe || extMode) cmp_bit("pinAtRefresh", 1'b0, pinWire);
    end else if (sw === 1'b0 && prevSw && (pinOe || extMode) && skipPin == 0) begin
      cmp_bit("pinAtOpen", 1'b1, pinWire);
    end
    prevSw = sw;
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    datW <= w ? d : 32'h0;
    if (!w) begin
      expQ.push_back(d);
      mskQ.push_back(m);
    end
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) cmp_bit("ackWait", 1'b1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic sync_to(input logic [3:0] ch);
    int n = 0;
    logic was = 1'b1;
    logic hit = 1'b0;
    while (!hit && n < 5000) begin
      @(negedge clk);
      hit = sw === 1'b1 && !was && rch === ch;
      was = sw;
      n++;
    end
    if (!hit) cmp_bit("refreshWait", 1'b1, hit);
    @(posedge clk);
  endtask

  task automatic view(input logic [3:0] ch);
    wb(1'b1, REG_VIEW_SEL, {28'h0, ch}, 32'h0);
    wb(1'b0, REG_LEVEL_VIEW, {6'h0, app[ch], 6'h0, tgt[ch]}, 32'h03FF03FF);
  endtask

  task automatic put(input logic src, input logic [3:0] ch, input logic [9:0] v, input int h);
    logic [15:0] e;
    sync_to(ch < 4'hA ? ch : 4'h0);
    rlsr_host_model_inst.send({16'h0, 1'b0, src, ch, v}, 16, h, e);
    if (ch < 4'hA) tgt[ch] = v;
    if (src != extMode) skipPin = 2;
    extMode = src;
    repeat (8) @(posedge clk);
    cmp_bit("pinDrive", ~src, pinOe);
    wb(1'b0, REG_STATUS, {30'h0, ~src, src}, 32'h3);
    view(ch < 4'hA ? ch : 4'h0);
  endtask

  initial begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      tgt[i] = 10'h000;
      app[i] = 10'h000;
    end
    void'($urandom(54));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cmp_bit("pinDriveAtReset", 1'b0, pinOe);
    wb(1'b0, REG_STATUS, 32'h0, 32'h0000000B);
    wb(1'b0, REG_STEP, {22'h0, STEP_RESET}, 32'hFFFFFFFF);
    wb(1'b0, REG_VIEW_SEL, {28'h0, VIEW_SEL_RESET}, 32'hFFFFFFFF);
    wb(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0);
    wb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
    $display("Test reset and registers done");
    put(1'b0, 4'h0, 10'h000, 4);
    put(1'b0, 4'h0, LEVEL_MAX_CODE, 4);
    put(1'b0, 4'h0, LEVEL_HALF_CODE, 4);
    put(1'b0, 4'h3, 10'h201, 4);
    put(1'b0, 4'h7, 10'h01F, 4);
    $display("Test code and address table done");
    sync_to(4'h1);
    wb(1'b1, REG_STEP, 32'h000003FF, 32'h0);
    stepVal = 10'h3FF;
    wb(1'b0, REG_STEP, 32'h000003FF, 32'hFFFFFFFF);
    for (int i = 1; i < 9; i = i * 2) put(1'b0, 4'(i), 10'($urandom), 4);
    $display("Test step limit and random codes done");
    sync_to(4'h5);
    rlsr_host_model_inst.send(32'h000017FF, 12, 4, echo);
    rlsr_host_model_inst.stray(4, 4);
    repeat (8) @(posedge clk);
    view(4'h5);
    put(1'b0, 4'hC, 10'($urandom), 4);
    $display("Test refused frames done");
    wordA = {2'b00, 14'($urandom)};
    code = 10'($urandom);
    sync_to(4'h6);
    rlsr_host_model_inst.send({wordA, 6'h06, code}, 32, 4, echo);
    cmp_bus("chainEcho", {16'h0, wordA}, {16'h0, echo});
    tgt[6] = code;
    repeat (8) @(posedge clk);
    view(4'h6);
    $display("Test daisy chain done");
    put(1'b1, 4'h9, 10'($urandom), 6);
    sync_to(4'h9);
    sync_to(4'h4);
    put(1'b0, 4'h2, 10'($urandom), 4);
    sync_to(4'h2);
    $display("Test refresh source modes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
